// *** hdl/lrap_defines.svh ***
`ifndef LRAP_DEFINES_SVH
`define LRAP_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define LRAP_CLK_NS        4
`define LRAP_MS_NS         1000000
`define LRAP_WAKE_UNIT_MS  100
`define LRAP_WAKE_DET_MS   35
`define LRAP_REM_UNIT_MS   10
`define LRAP_SLOT_MS       38
`define LRAP_RESP_WAIT_MS  2
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LRAP_CFG_OFS       8'h00
`define LRAP_ADDR_OFS      8'h04
`define LRAP_DEST_OFS      8'h08
`define LRAP_POLL_OFS      8'h0c
`define LRAP_PTIM_OFS      8'h10
`define LRAP_STAT_OFS      8'h14
// ----------------------------------------
// field positions
// ----------------------------------------
`define LRAP_CFG_WAKE_LSB  0
`define LRAP_CFG_MODE_LSB  8
`define LRAP_CFG_PAR_LSB   12
`define LRAP_CFG_MT_LSB    16
`define LRAP_CFG_RN_LSB    24
`define LRAP_HI16_LSB      16
`define LRAP_PTIM_RR_LSB   16
// ----------------------------------------
// reset values
// ----------------------------------------
`define LRAP_CFG_RST       32'h0000_0001
`define LRAP_ADDR_RST      32'hffff_ffff
`define LRAP_DEST_RST      32'h0000_0000
`define LRAP_POLL_RST      32'h0000_0000
`define LRAP_PTIM_RST      32'h0000_0000
`define LRAP_SRC_OFF       16'hffff
`define LRAP_LFSR_SEED     16'hace1
`endif

// *** hdl/lrap_link.sv ***
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "lrap_defines.svh"
module lrap_link
	import lrap_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `LRAP_MS_NS / `LRAP_CLK_NS
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// radio receive
	input  wire logic        rx_valid,
	input  wire logic [15:0] rx_dest,
	input  wire logic        rx_repeated,
	input  wire logic        rx_ack_req,
	input  wire logic        rx_is_poll,
	input  wire logic [7:0]  rx_mt_left,
	input  wire logic [15:0] rx_len_ms,
	input  wire logic        rf_wake_seen,
	input  wire logic        awake_release,
	output logic             rx_deliver,
	output logic             rx_send_ack,
	output logic             rx_retransmit,
	output logic             stay_awake,
	// transmit
	input  wire logic        tx_req,
	input  wire logic        tx_start,
	input  wire logic        ser_data_in,
	output logic             tx_grant,
	output logic      [8:0]  tx_copies,
	output logic             tx_ack_req,
	output logic      [15:0] tx_src_addr,
	output logic             wake_init_active,
	output logic             ser_discard,
	output lrap_pkg::lrap_parity_e uart_parity_select,
	// polling
	output logic             poll_req,
	output logic      [15:0] poll_addr
);
	// ----------------------------------------
	// registers and bus
	// ----------------------------------------
	logic [31:0] cfg_q, adr_q, dst_q, pol_q, ptm_q;
	logic        pready_q;
	wire  [7:0]  ofs = paddr[7:0];
	wire         hit = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'b00) && (ofs <= `LRAP_STAT_OFS);
	wire         wr  = psel & penable & pready_q & pwrite;
	wire  [7:0]  wake_init_duration      = cfg_q[`LRAP_CFG_WAKE_LSB +: 8];
	wire  [2:0]  radio_mode_select       = cfg_q[`LRAP_CFG_MODE_LSB +: 3];
	wire  [7:0]  forced_retransmit_count = cfg_q[`LRAP_CFG_MT_LSB +: 8];
	wire  [7:0]  backoff_slot_count      = cfg_q[`LRAP_CFG_RN_LSB +: 8];
	wire  [15:0] address_mask            = adr_q[15:0];
	wire  [15:0] source_address          = adr_q[`LRAP_HI16_LSB +: 16];
	wire  [15:0] destination_address     = dst_q[15:0];
	wire  [15:0] poll_begin_address      = pol_q[15:0];
	wire  [15:0] poll_end_address        = pol_q[`LRAP_HI16_LSB +: 16];
	wire  [15:0] poll_delay_timeout      = ptm_q[15:0];
	wire  [7:0]  retry_count             = ptm_q[`LRAP_PTIM_RR_LSB +: 8];
	wire         is_base   = (radio_mode_select == LRAP_MODE_POLL_BAS);
	wire         is_remote = (radio_mode_select == LRAP_MODE_POLL_REM);
	wire         is_rptr   = (radio_mode_select == LRAP_MODE_REPEATER);
	logic [31:0] stat, rdata;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `LRAP_CFG_RST;
			adr_q <= `LRAP_ADDR_RST;
			dst_q <= `LRAP_DEST_RST;
			pol_q <= `LRAP_POLL_RST;
			ptm_q <= `LRAP_PTIM_RST;
		end else if (wr) begin
			if (ofs == `LRAP_CFG_OFS) cfg_q <= pwdata;
			if (ofs == `LRAP_ADDR_OFS) adr_q <= pwdata;
			if (ofs == `LRAP_DEST_OFS) dst_q <= {16'h0, pwdata[15:0]};
			if (ofs == `LRAP_POLL_OFS) pol_q <= pwdata;
			if (ofs == `LRAP_PTIM_OFS) ptm_q <= {8'h0, pwdata[23:0]};
		end
	end

	always_comb begin
		case (ofs)
			`LRAP_CFG_OFS:  rdata = cfg_q;
			`LRAP_ADDR_OFS: rdata = adr_q;
			`LRAP_DEST_OFS: rdata = dst_q;
			`LRAP_POLL_OFS: rdata = pol_q;
			`LRAP_PTIM_OFS: rdata = ptm_q;
			`LRAP_STAT_OFS: rdata = stat;
			default:        rdata = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata   <= 32'h0;
			pslverr  <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr  <= psel & penable & ~pready_q & ~hit;
			if (psel & ~penable) prdata <= hit ? rdata : 32'h0;
		end
	end
	assign pready = pready_q;

	// ----------------------------------------
	// millisecond time base
	// ----------------------------------------
	logic ms;
	lrap_tick #(.CYCLES(MS_CYCLES)) u_ms (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (ms)
	);

	// ----------------------------------------
	// wake initializer send and detect
	// ----------------------------------------
	logic [14:0] wake_ms_q;
	logic [5:0]  det_ms_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_ms_q        <= '0;
			wake_init_active <= 1'b0;
		end else if (tx_start && !wake_init_active && wake_init_duration != 8'h0) begin
			wake_ms_q        <= 15'(wake_init_duration * `LRAP_WAKE_UNIT_MS);
			wake_init_active <= 1'b1;
		end else if (ms && wake_init_active) begin
			wake_ms_q        <= wake_ms_q - 15'd1;
			wake_init_active <= (wake_ms_q != 15'd1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_ms_q   <= '0;
			stay_awake <= 1'b0;
		end else begin
			if (!rf_wake_seen) det_ms_q <= '0;
			else if (ms && det_ms_q != 6'(`LRAP_WAKE_DET_MS)) det_ms_q <= det_ms_q + 6'd1;
			if (rf_wake_seen && det_ms_q == 6'(`LRAP_WAKE_DET_MS)) stay_awake <= 1'b1;
			else if (awake_release) stay_awake <= 1'b0;
		end
	end

	// ----------------------------------------
	// receive filter
	// ----------------------------------------
	wire [15:0] anded  = rx_dest & address_mask;
	wire        match  = (anded == destination_address) || (anded == address_mask);
	wire        sniff  = (address_mask == 16'h0);
	wire        fresh  = match & ~rx_repeated;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_deliver    <= 1'b0;
			rx_send_ack   <= 1'b0;
			rx_retransmit <= 1'b0;
		end else begin
			rx_deliver    <= rx_valid & (sniff | fresh);
			rx_send_ack   <= rx_valid & rx_ack_req & fresh & ~sniff;
			rx_retransmit <= rx_valid & is_rptr & ~match & ~rx_repeated;
		end
	end

	// ----------------------------------------
	// back-off after forced copies
	// ----------------------------------------
	lrap_bo_e    bo_q;
	logic [23:0] bo_ms_q;
	logic [15:0] lfsr_q;
	wire  [8:0]  slots   = 9'({1'b0, lfsr_q[7:0]} % ({1'b0, backoff_slot_count} + 9'h1));
	wire  [23:0] slot_ms = 24'(slots * `LRAP_SLOT_MS);
	wire         tx_ok   = (bo_q == LRAP_B_IDLE);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lfsr_q <= `LRAP_LFSR_SEED;
		else lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bo_q    <= LRAP_B_IDLE;
			bo_ms_q <= '0;
		end else if (rx_valid && rx_mt_left != 8'h0) begin
			bo_q    <= LRAP_B_HOLD;
			bo_ms_q <= 24'(rx_len_ms) * 24'(rx_mt_left);
		end else begin
			unique case (bo_q)
				LRAP_B_IDLE: bo_ms_q <= '0;
				LRAP_B_HOLD: if (bo_ms_q == 24'h0) begin
					bo_q    <= LRAP_B_SLOT;
					bo_ms_q <= slot_ms;
				end else if (ms) bo_ms_q <= bo_ms_q - 24'h1;
				LRAP_B_SLOT: if (bo_ms_q == 24'h0) bo_q <= LRAP_B_IDLE;
					else if (ms) bo_ms_q <= bo_ms_q - 24'h1;
				default: bo_q <= LRAP_B_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// transmit gate and remote hold
	// ----------------------------------------
	logic        poll_seen_q, held_q;
	logic [19:0] age_ms_q;
	wire         can_tx = tx_ok & (~is_remote | poll_seen_q);
	wire         go     = tx_req & can_tx & ~tx_grant;
	wire         stale  = held_q && age_ms_q >= 20'(poll_delay_timeout * `LRAP_REM_UNIT_MS);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_grant    <= 1'b0;
			tx_copies   <= 9'h1;
			tx_ack_req  <= 1'b1;
			tx_src_addr <= 16'h0;
			poll_seen_q <= 1'b0;
		end else begin
			tx_grant    <= go;
			tx_copies   <= (forced_retransmit_count != 8'h0) ? {1'b0, forced_retransmit_count} + 9'h1
				: {1'b0, retry_count} + 9'h1;
			tx_ack_req  <= (forced_retransmit_count == 8'h0);
			tx_src_addr <= (source_address == `LRAP_SRC_OFF) ? destination_address : source_address;
			if (rx_valid && rx_is_poll && match && is_remote) poll_seen_q <= 1'b1;
			else if (go || !is_remote) poll_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_q      <= 1'b0;
			age_ms_q    <= '0;
			ser_discard <= 1'b0;
		end else begin
			ser_discard <= is_remote & stale & ~go;
			if (ser_data_in) begin
				held_q   <= 1'b1;
				age_ms_q <= '0;
			end else if (go || (is_remote && stale)) held_q <= 1'b0;
			else if (ms && held_q && age_ms_q != 20'hfffff) age_ms_q <= age_ms_q + 20'h1;
		end
	end
	assign uart_parity_select = lrap_parity_e'(cfg_q[`LRAP_CFG_PAR_LSB +: 3]);

	// ----------------------------------------
	// poll base sequencer
	// ----------------------------------------
	lrap_poll_e  ps_q;
	logic [15:0] cur_q, cyc_ms_q;
	logic [7:0]  wt_ms_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_q      <= LRAP_P_IDLE;
			cur_q     <= '0;
			cyc_ms_q  <= '0;
			wt_ms_q   <= '0;
			poll_req  <= 1'b0;
			poll_addr <= '0;
		end else begin
			poll_req <= 1'b0;
			if (ms && ps_q != LRAP_P_IDLE && cyc_ms_q != 16'hffff) cyc_ms_q <= cyc_ms_q + 16'h1;
			if (!is_base) ps_q <= LRAP_P_IDLE;
			else unique case (ps_q)
				LRAP_P_IDLE: begin
					cur_q    <= poll_begin_address;
					cyc_ms_q <= '0;
					ps_q     <= LRAP_P_SEND;
				end
				LRAP_P_SEND: begin
					poll_req  <= 1'b1;
					poll_addr <= cur_q;
					wt_ms_q   <= '0;
					ps_q      <= LRAP_P_WAIT;
				end
				LRAP_P_WAIT: begin
					if (ms) wt_ms_q <= wt_ms_q + 8'h1;
					if (rx_valid || wt_ms_q >= 8'(`LRAP_RESP_WAIT_MS)) begin
						if (cur_q == poll_end_address) ps_q <= LRAP_P_GAP;
						else begin
							cur_q <= cur_q + 16'h1;
							ps_q  <= LRAP_P_SEND;
						end
					end
				end
				LRAP_P_GAP: if (cyc_ms_q >= poll_delay_timeout) begin
					cyc_ms_q <= '0;
					cur_q    <= poll_begin_address;
					ps_q     <= LRAP_P_SEND;
				end
			endcase
		end
	end
	assign stat = {11'h0, held_q, poll_seen_q, tx_ok, stay_awake, wake_init_active, poll_addr};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence apb_wr_s;
		psel && penable && pready_q && pwrite && ofs == `LRAP_CFG_OFS;
	endsequence
	cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_wr_s |=> radio_mode_select == $past(pwdata[`LRAP_CFG_MODE_LSB +: 3]))
		else $error("config write lost");
	wake_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_start && !wake_init_active && wake_init_duration != 8'h0
		|=> wake_init_active && wake_ms_q == 15'($past(wake_init_duration) * `LRAP_WAKE_UNIT_MS))
		else $error("wake initializer not started");
	stay_awake_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stay_awake) |-> $past(rf_wake_seen) && $past(det_ms_q) == 6'(`LRAP_WAKE_DET_MS))
		else $error("awake without full initializer");
	remote_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_grant && $past(is_remote) |-> $past(poll_seen_q))
		else $error("remote sent without poll");
	repeat_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && (rx_repeated || match || !is_rptr) |=> !rx_retransmit)
		else $error("bad retransmit");
	mask_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && !match && !sniff |=> !rx_deliver)
		else $error("unmatched packet delivered");
	sniffer_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && sniff |=> rx_deliver && !rx_send_ack)
		else $error("sniffer frame lost or acked");
	multi_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_grant && $past(forced_retransmit_count) != 8'h0
		|-> tx_copies == {1'b0, $past(forced_retransmit_count)} + 9'h1 && !tx_ack_req)
		else $error("wrong forced copy count");
	inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_valid && rx_mt_left != 8'h0 && rx_len_ms != 16'h0 |=> !tx_ok [*2])
		else $error("no inhibit after forced copy");
	poll_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		ps_q == LRAP_P_GAP && is_base && cyc_ms_q >= poll_delay_timeout |=> ##1 poll_req
		&& poll_addr == $past(poll_begin_address, 2))
		else $error("poll cycle did not restart at begin");
endmodule // lrap_link

// *** hdl/lrap_pkg.sv ***
package lrap_pkg;
	typedef enum logic [2:0] {
		LRAP_MODE_TRANSP   = 3'b000,
		LRAP_MODE_RSV1     = 3'b001,
		LRAP_MODE_RSV2     = 3'b010,
		LRAP_MODE_POLL_BAS = 3'b011,
		LRAP_MODE_POLL_REM = 3'b100,
		LRAP_MODE_REPEATER = 3'b101,
		LRAP_MODE_END_NODE = 3'b110,
		LRAP_MODE_RSV7     = 3'b111
	} lrap_mode_e;
	typedef enum logic [2:0] {
		LRAP_PAR_NONE  = 3'b000,
		LRAP_PAR_EVEN  = 3'b001,
		LRAP_PAR_ODD   = 3'b010,
		LRAP_PAR_MARK  = 3'b011,
		LRAP_PAR_SPACE = 3'b100
	} lrap_parity_e;
	typedef enum logic [1:0] {
		LRAP_P_IDLE = 2'b00,
		LRAP_P_SEND = 2'b01,
		LRAP_P_WAIT = 2'b10,
		LRAP_P_GAP  = 2'b11
	} lrap_poll_e;
	typedef enum logic [1:0] {
		LRAP_B_IDLE = 2'b00,
		LRAP_B_HOLD = 2'b01,
		LRAP_B_SLOT = 2'b10
	} lrap_bo_e;
endpackage

// *** hdl/lrap_tick.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// periodic one-cycle tick
// ----------------------------------------
module lrap_tick #(
	parameter int unsigned CYCLES = 250000
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// tick out
	output logic      tick
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	logic [W-1:0] cnt_q;
	wire          wrap = (cnt_q == LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_q <= wrap ? '0 : cnt_q + W'(1);
			tick  <= wrap;
		end
	end
endmodule // lrap_tick

// *** sim/lrap_radio_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// remote radio across the air link
// ----------------------------------------
module lrap_radio_model #(
	parameter logic [15:0] ANS_ADDR = 16'h0006
) (
	// clock
	input  wire logic        pclk,
	// polls from the base
	input  wire logic        poll_req,
	input  wire logic [15:0] poll_addr,
	// packets handed to the receiver
	output logic             rx_valid,
	output logic      [15:0] rx_dest,
	output logic             rx_repeated,
	output logic             rx_ack_req,
	output logic             rx_is_poll,
	output logic      [7:0]  rx_mt_left,
	output logic      [15:0] rx_len_ms
);
	initial begin
		rx_valid = 1'h0;
		rx_dest = 16'h0000;
		rx_repeated = 1'h0;
		rx_ack_req = 1'h0;
		rx_is_poll = 1'h0;
		rx_mt_left = 8'h00;
		rx_len_ms = 16'h0000;
	end
	task automatic send_pkt(input logic [15:0] d, input logic rep, ak, pl, input logic [7:0] mt,
		input logic [15:0] ln);
		@(posedge pclk);
		rx_valid <= 1'h1;
		rx_dest <= d;
		rx_repeated <= rep;
		rx_ack_req <= ak;
		rx_is_poll <= pl;
		rx_mt_left <= mt;
		rx_len_ms <= ln;
		@(posedge pclk);
		// fields turn over once the pulse is gone
		rx_valid <= 1'h0;
		rx_dest <= ~d;
		rx_repeated <= ~rep;
		rx_ack_req <= ~ak;
		rx_is_poll <= ~pl;
		rx_mt_left <= ~mt;
		rx_len_ms <= ~ln;
	endtask
	// only one remote holds data; the others stay silent
	initial forever begin
		@(posedge pclk);
		if (poll_req === 1'h1 && poll_addr === ANS_ADDR) begin
			send_pkt(ANS_ADDR, 1'h0, 1'h0, 1'h0, 8'h00, 16'h0001);
		end
	end
endmodule // lrap_radio_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "lrap_defines.svh"
module tb;
	import lrap_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int unsigned MS = 10;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0]  paddr, pwdata, prdata, rd;
	logic         rx_valid, rx_repeated, rx_ack_req, rx_is_poll, rf_wake_seen, awake_release;
	logic [15:0]  rx_dest, rx_len_ms, tx_src_addr, poll_addr;
	logic [7:0]   rx_mt_left;
	logic         rx_deliver, rx_send_ack, rx_retransmit, stay_awake, tx_req, tx_start, ser_data_in;
	logic         tx_grant, tx_ack_req, wake_init_active, ser_discard, poll_req;
	logic [8:0]   tx_copies;
	lrap_parity_e uart_parity_select;
	int           n_mismatch = 0, n_checks = 0, cyc = 0, n;
	int           pt[$];
	logic [15:0]  pa[$];
	lrap_link #(.MS_CYCLES(MS)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_dest(rx_dest), .rx_repeated(rx_repeated), .rx_ack_req(rx_ack_req), .rx_is_poll(rx_is_poll),
		.rx_mt_left(rx_mt_left), .rx_len_ms(rx_len_ms), .rf_wake_seen(rf_wake_seen),
		.awake_release(awake_release), .rx_deliver(rx_deliver), .rx_send_ack(rx_send_ack),
		.rx_retransmit(rx_retransmit), .stay_awake(stay_awake), .tx_req(tx_req), .tx_start(tx_start),
		.ser_data_in(ser_data_in), .tx_grant(tx_grant), .tx_copies(tx_copies), .tx_ack_req(tx_ack_req),
		.tx_src_addr(tx_src_addr), .wake_init_active(wake_init_active), .ser_discard(ser_discard),
		.uart_parity_select(uart_parity_select), .poll_req(poll_req), .poll_addr(poll_addr)
	);
	lrap_radio_model i_radio (
		.pclk(pclk), .poll_req(poll_req), .poll_addr(poll_addr), .rx_valid(rx_valid), .rx_dest(rx_dest),
		.rx_repeated(rx_repeated), .rx_ack_req(rx_ack_req), .rx_is_poll(rx_is_poll),
		.rx_mt_left(rx_mt_left), .rx_len_ms(rx_len_ms)
	);
	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	// poll log with cycle stamps
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (poll_req === 1'h1) begin
			pa.push_back(poll_addr);
			pt.push_back(cyc);
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic hang();
		n_mismatch++;
		$display("unexpected at %0t: wait ran out", $time);
		print_verdict();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			k++;
			if (k > 20) hang();
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'h0, a, 32'h0);
		check(rd, exp);
		check({31'h0, er}, {31'h0, e});
	endtask
	task automatic wait_for(ref logic s, input logic v, input int lim, output int c);
		c = 0;
		while (s !== v) begin
			@(posedge pclk);
			c++;
			if (c > lim) hang();
		end
	endtask
	task automatic quiet(ref logic s, input int cnt);
		logic seen = 1'h0;
		repeat (cnt) begin
			@(posedge pclk);
			seen |= (s !== 1'h0);
		end
		check({31'h0, seen}, 32'h0);
	endtask
	// flags {repeated, ack request, poll}; expect {deliver, ack, retransmit}
	task automatic pkt(input logic [15:0] d, input logic [2:0] f, input logic [2:0] e);
		i_radio.send_pkt(d, f[2], f[1], f[0], 8'h00, 16'h0001);
		@(posedge pclk);
		check({29'h0, rx_deliver, rx_send_ack, rx_retransmit}, {29'h0, e});
	endtask
	function automatic logic [31:0] cfg(input logic [7:0] w, input logic [2:0] m, p, input logic [7:0] mt, rn);
		return {rn, mt, 1'h0, p, 1'h0, m, w};
	endfunction
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		rf_wake_seen = 1'h0;
		awake_release = 1'h0;
		tx_req = 1'h0;
		tx_start = 1'h0;
		ser_data_in = 1'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rdc(`LRAP_CFG_OFS, 32'h0000_0001, 1'h0);
		rdc(`LRAP_ADDR_OFS, 32'hffff_ffff, 1'h0);
		rdc(`LRAP_POLL_OFS, 32'h0, 1'h0);
		rdc(`LRAP_PTIM_OFS, 32'h0, 1'h0);
		rdc(`LRAP_STAT_OFS, 32'h0004_0000, 1'h0);
		rdc(8'h18, 32'h0, 1'h1);
		wr(`LRAP_DEST_OFS, 32'h0000_0012);
		repeat (2) @(posedge pclk);
		check({16'h0, tx_src_addr}, 32'h0000_0012);
		wr(`LRAP_ADDR_OFS, 32'habcd_ffff);
		repeat (2) @(posedge pclk);
		check({16'h0, tx_src_addr}, 32'h0000_abcd);
		wr(`LRAP_ADDR_OFS, 32'hffff_00ff);
		pkt(16'h1212, 3'h2, 3'h6);
		pkt(16'h34ff, 3'h2, 3'h6);
		pkt(16'h0013, 3'h2, 3'h0);
		pkt(16'h1212, 3'h6, 3'h0);
		wr(`LRAP_ADDR_OFS, 32'hffff_0000);
		pkt(16'h5555, 3'h6, 3'h4);
		wr(`LRAP_ADDR_OFS, 32'hffff_ffff);
		wr(`LRAP_CFG_OFS, cfg(8'h01, 3'h5, 3'h0, 8'h00, 8'h00));
		pkt(16'h0099, 3'h0, 3'h1);
		pkt(16'h0012, 3'h0, 3'h4);
		pkt(16'h0099, 3'h4, 3'h0);
		wr(`LRAP_CFG_OFS, cfg(8'h01, 3'h6, 3'h0, 8'h00, 8'h00));
		pkt(16'h0099, 3'h0, 3'h0);
		for (int p = 0; p < 5; p++) begin
			wr(`LRAP_CFG_OFS, cfg(8'h01, 3'h0, 3'(p), 8'h00, 8'h00));
			check(32'(uart_parity_select), 32'(p));
		end
		// forced copies heard, then sending with and without multi-transmit
		wr(`LRAP_PTIM_OFS, 32'h0002_0000);
		for (int r = 0; r < 2; r++) begin
			wr(`LRAP_CFG_OFS, cfg(8'h01, 3'h0, 3'h0, 8'(r * 4), 8'(r)));
			i_radio.send_pkt(16'h0777, 1'h0, 1'h0, 1'h0, 8'h02, 16'h0003);
			tx_req <= 1'h1;
			wait_for(tx_grant, 1'h1, 100 + r * 400, n);
			tx_req <= 1'h0;
			check(32'(n >= 45 && n <= 75 + r * 385), 32'h1);
			check({22'h0, tx_copies, tx_ack_req}, r ? 32'h0000_000a : 32'h0000_0007);
		end
		wr(`LRAP_CFG_OFS, cfg(8'h01, 3'h4, 3'h0, 8'h00, 8'h00));
		tx_req <= 1'h1;
		quiet(tx_grant, 30);
		i_radio.send_pkt(16'h0012, 1'h0, 1'h0, 1'h1, 8'h00, 16'h0001);
		wait_for(tx_grant, 1'h1, 5, n);
		tx_req <= 1'h0;
		check({31'h0, tx_grant}, 32'h1);
		wr(`LRAP_PTIM_OFS, 32'h0000_0002);
		ser_data_in <= 1'h1;
		@(posedge pclk);
		ser_data_in <= 1'h0;
		wait_for(ser_discard, 1'h1, 300, n);
		check(32'(n >= 185 && n <= 215), 32'h1);
		// base walks 5..7 with a 20 ms cycle
		wr(`LRAP_POLL_OFS, 32'h0007_0005);
		wr(`LRAP_PTIM_OFS, 32'h0000_0014);
		pa.delete();
		pt.delete();
		wr(`LRAP_CFG_OFS, cfg(8'h01, 3'h3, 3'h0, 8'h00, 8'h00));
		repeat (260) @(posedge pclk);
		wr(`LRAP_CFG_OFS, cfg(8'h01, 3'h0, 3'h0, 8'h00, 8'h00));
		for (int i = 0; i < 4; i++) check({16'h0, pa[i]}, 32'(5 + i % 3));
		check(32'(pt[2] - pt[1] < pt[1] - pt[0]), 32'h1);
		check(32'(pt[3] - pt[0] >= 185 && pt[3] - pt[0] <= 215), 32'h1);
		// 200 ms, longer than any receiver sleep interval
		wr(`LRAP_CFG_OFS, cfg(8'h02, 3'h0, 3'h0, 8'h00, 8'h00));
		tx_start <= 1'h1;
		@(posedge pclk);
		tx_start <= 1'h0;
		wait_for(wake_init_active, 1'h1, 5, n);
		wait_for(wake_init_active, 1'h0, 2100, n);
		check(32'(n >= 1985 && n <= 2015), 32'h1);
		rf_wake_seen <= 1'h1;
		quiet(stay_awake, 200);
		rf_wake_seen <= 1'h0;
		quiet(stay_awake, 200);
		rf_wake_seen <= 1'h1;
		wait_for(stay_awake, 1'h1, 400, n);
		check(32'(n >= 335 && n <= 365), 32'h1);
		rf_wake_seen <= 1'h0;
		awake_release <= 1'h1;
		@(posedge pclk);
		awake_release <= 1'h0;
		wait_for(stay_awake, 1'h0, 5, n);
		print_verdict();
	end
endmodule // tb
